// ===== rtl/scc_pkg.sv
package scc_pkg;

    // Register offsets on the configuration port
    localparam logic [14:0] ADDR_CLOCK_SYSREF_CONTROL = 15'h0029;
    localparam logic [14:0] ADDR_CLOCK_INPUT_OPTIONS  = 15'h002a;
    localparam logic [14:0] ADDR_CLOCK_PATH_TUNING    = 15'h002b;

    // Reset values
    localparam logic [7:0] RST_CLOCK_SYSREF_CONTROL = 8'h00;
    localparam logic [7:0] RST_CLOCK_INPUT_OPTIONS  = 8'h00;
    localparam logic [7:0] RST_CLOCK_PATH_TUNING    = 8'h11;

    // clock_sysref_control fields
    localparam int SYSREF_PROCESSOR_ENABLE_BIT = 6;
    localparam int SYSREF_RECEIVER_ENABLE_BIT  = 5;
    localparam int WINDOW_FINE_STEP_BIT        = 4;
    localparam int CAPTURE_DELAY_SELECT_MSB    = 3;
    localparam int CAPTURE_DELAY_SELECT_LSB    = 0;

    // clock_input_options fields
    localparam int SYSREF_AS_MARKER_ENABLE_BIT      = 3;
    localparam int DEVICE_CLOCK_DC_COUPLED_MODE_BIT = 2;
    localparam int SYSREF_DC_COUPLED_MODE_BIT       = 1;
    localparam int SYSREF_POLARITY_FLIP_BIT         = 0;

    // clock_path_tuning fields
    localparam int FEEDBACK_GAIN_HIGH_BIT           = 4;
    localparam int SUPPLY_NOISE_SUPPRESS_ENABLE_BIT = 2;
    localparam int SAMPLE_CLOCK_DELAY_MSB           = 1;
    localparam int SAMPLE_CLOCK_DELAY_LSB           = 0;

    // Value returned for an address outside this bank
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

endpackage

// ===== rtl/scc_byte_reg.sv
`timescale 1ns/1ps

// One byte-wide read/write configuration register
module scc_byte_reg #(
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       resetn,
    // Write side
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    // Stored value
    output logic [7:0]      value
);

    logic [7:0] value_reg;
    logic [7:0] value_next;

    // Reserved bits are stored like the rest so they read back as written
    always_comb begin
        value_next = value_reg;
        if (wr_en) begin
            value_next = wr_data;
        end
    end

    // Reset takes the constant reset value only
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            value_reg <= RESET_VALUE;
        end else begin
            value_reg <= value_next;
        end
    end

    assign value = value_reg;

endmodule

// ===== rtl/scc_regs.sv
`timescale 1ns/1ps

// Contract
// - Bit 6 of clock_sysref_control enables the SYSREF processor; resets disabled.
// - Bit 5 of clock_sysref_control switches on the SYSREF receiver; resets disabled.
// - window_fine_step in bit 4 selects smaller windowing delay steps.
// - capture_delay_select in bits 3:0 picks the applied SYSREF capture delay.
// - Marker bit plus output marker enable put SYSREF on sample LSB, bypass only.
// - Bit 2 selects DC-coupled clock input mode, bit 1 for SYSREF input.
// - sysref_polarity_flip in bit 0 of clock_input_options inverts aligned SYSREF.
// - Bit 4 of clock_path_tuning sets high feedback gain when one; resets one.
// - supply_noise_suppress_enable in bit 2 suppresses supply noise on analog clock.
// - sample_clock_delay in bits 1:0 is one-hot sampling clock delay; resets one.
// - After reset the first two registers read zero, the third reads 0x11.

module scc_regs (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // Register port from the serial configuration engine
    input  wire logic [14:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    output logic             reg_hit,
    // SYSREF path in
    input  wire logic        sysref_pin,
    input  wire logic        output_marker_enable,
    input  wire logic        decimation_bypass,
    input  wire logic        sample_lsb_in,
    // SYSREF path out
    output logic             sysref_receiver_on,
    output logic             sysref_processor_on,
    output logic             sysref_event,
    output logic             sample_lsb_out,
    output logic             window_fine_step,
    output logic [3:0]       capture_delay_select,
    // Clock input and clock path controls
    output logic             device_clock_dc_coupled_mode,
    output logic             sysref_dc_coupled_mode,
    output logic             feedback_gain_high,
    output logic             supply_noise_suppress_enable,
    output logic [1:0]       sample_clock_delay
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage

    logic [7:0] sysref_ctrl;
    logic [7:0] input_opts;
    logic [7:0] path_tuning;
    logic       wr_ctrl;
    logic       wr_opts;
    logic       wr_tune;

    // Address decode of the three writable bytes
    assign wr_ctrl = reg_wr && (reg_addr == scc_pkg::ADDR_CLOCK_SYSREF_CONTROL);
    assign wr_opts = reg_wr && (reg_addr == scc_pkg::ADDR_CLOCK_INPUT_OPTIONS);
    assign wr_tune = reg_wr && (reg_addr == scc_pkg::ADDR_CLOCK_PATH_TUNING);

    scc_byte_reg #(
        .RESET_VALUE (scc_pkg::RST_CLOCK_SYSREF_CONTROL)
    ) u_sysref_ctrl (
        .clock   (clock),
        .resetn  (resetn),
        .wr_en   (wr_ctrl),
        .wr_data (reg_wdata),
        .value   (sysref_ctrl)
    );

    scc_byte_reg #(
        .RESET_VALUE (scc_pkg::RST_CLOCK_INPUT_OPTIONS)
    ) u_input_opts (
        .clock   (clock),
        .resetn  (resetn),
        .wr_en   (wr_opts),
        .wr_data (reg_wdata),
        .value   (input_opts)
    );

    scc_byte_reg #(
        .RESET_VALUE (scc_pkg::RST_CLOCK_PATH_TUNING)
    ) u_path_tuning (
        .clock   (clock),
        .resetn  (resetn),
        .wr_en   (wr_tune),
        .wr_data (reg_wdata),
        .value   (path_tuning)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read back

    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       hit_reg;
    logic       hit_next;

    // Whole byte returned, reserved bits included, since they are read/write
    always_comb begin
        rdata_next = rdata_reg;
        hit_next   = 1'b0;
        if (reg_rd) begin
            hit_next = 1'b1;
            unique case (reg_addr)
                scc_pkg::ADDR_CLOCK_SYSREF_CONTROL: rdata_next = sysref_ctrl;
                scc_pkg::ADDR_CLOCK_INPUT_OPTIONS:  rdata_next = input_opts;
                scc_pkg::ADDR_CLOCK_PATH_TUNING:    rdata_next = path_tuning;
                default: begin
                    rdata_next = scc_pkg::UNMAPPED_READ_VALUE;
                    hit_next   = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 8'h00;
            hit_reg   <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            hit_reg   <= hit_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_hit   = hit_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Field outputs

    assign sysref_receiver_on = sysref_ctrl[scc_pkg::SYSREF_RECEIVER_ENABLE_BIT];
    assign sysref_processor_on = sysref_ctrl[scc_pkg::SYSREF_PROCESSOR_ENABLE_BIT];
    assign window_fine_step = sysref_ctrl[scc_pkg::WINDOW_FINE_STEP_BIT];
    assign capture_delay_select =
        sysref_ctrl[scc_pkg::CAPTURE_DELAY_SELECT_MSB:scc_pkg::CAPTURE_DELAY_SELECT_LSB];
    assign device_clock_dc_coupled_mode =
        input_opts[scc_pkg::DEVICE_CLOCK_DC_COUPLED_MODE_BIT];
    assign sysref_dc_coupled_mode = input_opts[scc_pkg::SYSREF_DC_COUPLED_MODE_BIT];
    assign feedback_gain_high = path_tuning[scc_pkg::FEEDBACK_GAIN_HIGH_BIT];
    assign supply_noise_suppress_enable =
        path_tuning[scc_pkg::SUPPLY_NOISE_SUPPRESS_ENABLE_BIT];
    // one-hot delay passed as written, software keeps it one-hot
    assign sample_clock_delay =
        path_tuning[scc_pkg::SAMPLE_CLOCK_DELAY_MSB:scc_pkg::SAMPLE_CLOCK_DELAY_LSB];

    ////////////////////////////////////////////////////////////////////////////
    // SYSREF path

    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    logic event_reg;
    logic lsb_reg;
    logic sync1_next;
    logic sync2_next;
    logic prev_next;
    logic event_next;
    logic lsb_next;
    logic aligned;
    logic rx_live;
    logic marker_on;

    // a receiver that is off presents a quiet low level
    assign rx_live = sysref_receiver_on && sync2_reg;

    // polarity flip applied to the level used for alignment
    assign aligned = rx_live ^ input_opts[scc_pkg::SYSREF_POLARITY_FLIP_BIT];

    // marker needs both enables and decimation bypass
    assign marker_on = input_opts[scc_pkg::SYSREF_AS_MARKER_ENABLE_BIT]
                       && output_marker_enable && decimation_bypass;

    // Pin passes two flops before use; events are rising edges of aligned level
    always_comb begin
        sync1_next = sysref_pin;
        sync2_next = sync1_reg;
        prev_next  = aligned;
        // events only handled while the processor is enabled
        event_next = sysref_processor_on && aligned && !prev_reg;
        lsb_next   = marker_on ? aligned : sample_lsb_in;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg  <= 1'b0;
            event_reg <= 1'b0;
            lsb_reg   <= 1'b0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            prev_reg  <= prev_next;
            event_reg <= event_next;
            lsb_reg   <= lsb_next;
        end
    end

    assign sysref_event   = event_reg;
    assign sample_lsb_out = lsb_reg;

endmodule

// ===== testbench/scc_regs_chk.sv
`timescale 1ns/1ps
////////////////////////////////////////
module scc_regs_chk (
    // Clock and reset
    input wire logic        clock,
    input wire logic        resetn,
    // Register port
    input wire logic [14:0] reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_hit,
    // Field outputs
    input wire logic        sysref_receiver_on,
    input wire logic        sysref_processor_on,
    input wire logic        sysref_event,
    input wire logic [3:0]  capture_delay_select,
    input wire logic        feedback_gain_high,
    input wire logic [1:0]  sample_clock_delay
);
    logic mapped;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // Address falls inside the three-byte bank
    assign mapped = reg_addr inside {15'h0029, 15'h002a, 15'h002b};
    // Request steps
    sequence rd_map_s; reg_rd && mapped; endsequence
    sequence wr_ctrl_s; reg_wr && reg_addr == 15'h0029; endsequence
    sequence wr_tune_s; reg_wr && reg_addr == 15'h002b; endsequence
    hit_mapped_a: assert property (rd_map_s |=> reg_hit)
        else $error("no hit on mapped read");
    unmap_read_a: assert property (reg_rd && !mapped |=> !reg_hit && reg_rdata == 8'h00)
        else $error("unmapped read answered");
    hit_cause_a: assert property (reg_hit |-> $past(reg_rd && mapped))
        else $error("hit without mapped read");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    ctrl_write_a: assert property (wr_ctrl_s |=>
        {sysref_processor_on, sysref_receiver_on, capture_delay_select}
        == {$past(reg_wdata[6:5]), $past(reg_wdata[3:0])})
        else $error("control fields wrong");
    tune_write_a: assert property (wr_tune_s |=>
        {feedback_gain_high, sample_clock_delay}
        == {$past(reg_wdata[4]), $past(reg_wdata[1:0])})
        else $error("tuning fields wrong");
    event_gate_a: assert property (sysref_event |-> $past(sysref_processor_on))
        else $error("event with processor off");
    event_pulse_a: assert property (sysref_event |=> !sysref_event)
        else $error("event longer than a cycle");
endmodule
bind scc_regs scc_regs_chk i_scc_regs_chk (.*);

// ===== testbench/scc_host.sv
`timescale 1ns/1ps
////////////////////////////////////////
module scc_host (
    // Clock
    input  wire logic        clock,
    // Register port towards the bank
    output logic [14:0]      reg_addr,
    output logic             reg_wr,
    output logic [7:0]       reg_wdata,
    output logic             reg_rd,
    input  wire logic [7:0]  reg_rdata,
    input  wire logic        reg_hit
);
    // Idle bus at time zero
    initial begin
        reg_addr = 15'h0000;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // One-cycle write strobe, launched just after an edge
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        @(posedge clock) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clock) #1;
        reg_wr = 1'b0;
        reg_wdata = ~d; // Stale data never lingers on the bus
    endtask
    // Read: answer is settled one edge after the strobe
    task automatic rd(input logic [14:0] a, output logic [7:0] d, output logic h);
        @(posedge clock) #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clock) #1;
        reg_rd = 1'b0;
        d = reg_rdata;
        h = reg_hit;
    endtask
endmodule

// ===== testbench/test_sysref_clock_control_regs.sv
`timescale 1ns/1ps
////////////////////////////////////////
module test_sysref_clock_control_regs;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic [14:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, d;
    logic        reg_wr, reg_rd, reg_hit, h, rx_on, proc_on, ev, lsb_out, fine;
    logic        dev_dc, sr_dc, gain, noise;
    logic        pin = 1'b0, mark = 1'b0, byp = 1'b0, lsb_in = 1'b0;
    logic [3:0]  sel;
    logic [1:0]  sdel;
    int          e, n_errors = 0, samples_checked = 0;
    // Free-running 40 MHz clock
    always #12.5 clock = ~clock;
    scc_host i_scc_host (.clock, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_hit);
    scc_regs i_scc_regs (.clock, .resetn, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
        .reg_rdata, .reg_hit, .sysref_pin(pin), .output_marker_enable(mark),
        .decimation_bypass(byp), .sample_lsb_in(lsb_in), .sysref_receiver_on(rx_on),
        .sysref_processor_on(proc_on), .sysref_event(ev), .sample_lsb_out(lsb_out),
        .window_fine_step(fine), .capture_delay_select(sel),
        .device_clock_dc_coupled_mode(dev_dc), .sysref_dc_coupled_mode(sr_dc),
        .feedback_gain_high(gain), .supply_noise_suppress_enable(noise),
        .sample_clock_delay(sdel));
    ////////////////////////////////////////
    task chk(input logic [7:0] g, input logic [7:0] x);
        samples_checked++;
        if (g !== x) begin
            n_errors++;
            $display("Error t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task rdchk(input logic [14:0] a, input logic [7:0] x, input logic xh);
        i_scc_host.rd(a, d, h);
        chk(d, x);
        chk({7'h00, h}, {7'h00, xh});
    endtask
    // Count event pulses while the pin sits at one level
    task win(input logic v);
        pin = v;
        e = 0;
        repeat (8) begin
            @(posedge clock) #1;
            e += int'(ev === 1'b1);
        end
    endtask
    task test_done;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////
    task t_reset;
        rdchk(15'h0029, 8'h00, 1'b1);
        rdchk(15'h002a, 8'h00, 1'b1);
        rdchk(15'h002b, 8'h11, 1'b1);
        chk({3'h0, gain, noise, proc_on, sdel}, 8'h11);
    endtask
    task t_fields;
        // Receiver goes on before the processor
        i_scc_host.wr(15'h0029, 8'h20);
        i_scc_host.wr(15'h0029, 8'h75);
        chk({1'b0, proc_on, rx_on, fine, sel}, 8'h75);
        i_scc_host.wr(15'h002a, 8'h06);
        chk({6'h00, dev_dc, sr_dc}, 8'h03);
        i_scc_host.wr(15'h002b, 8'h06);
        chk({4'h0, gain, noise, sdel}, 8'h06);
        rdchk(15'h002b, 8'h06, 1'b1);
    endtask
    task t_unmapped;
        i_scc_host.wr(15'h002c, 8'hff);
        rdchk(15'h002c, 8'h00, 1'b0);
        rdchk(15'h0029, 8'h75, 1'b1);
    endtask
    task t_sysref;
        win(1'b1);
        chk(e[7:0], 8'h01);
        win(1'b0);
        chk(e[7:0], 8'h00);
        win(1'b1);
        mark = 1'b1;
        byp = 1'b1;
        lsb_in = 1'b1;
        i_scc_host.wr(15'h002a, 8'h0f);
        repeat (4) @(posedge clock) #1;
        chk({7'h00, lsb_out}, 8'h00);
        lsb_in = 1'b0;
        win(1'b0);
        chk(e[7:0], 8'h01);
        chk({7'h00, lsb_out}, 8'h01);
        byp = 1'b0;
        repeat (4) @(posedge clock) #1;
        chk({7'h00, lsb_out}, 8'h00);
        // Aligned level is high here, so a wrongly active marker would show a one
        byp = 1'b1;
        mark = 1'b0;
        repeat (4) @(posedge clock) #1;
        chk({7'h00, lsb_out}, 8'h00);
        mark = 1'b1;
        i_scc_host.wr(15'h002a, 8'h07);
        repeat (4) @(posedge clock) #1;
        chk({7'h00, lsb_out}, 8'h00);
    endtask
    task t_proc_off;
        i_scc_host.wr(15'h0029, 8'h20);
        win(1'b1);
        win(1'b0);
        chk(e[7:0], 8'h00);
    endtask
    // Reset in mid-run must bring clock_input_options and clock_path_tuning back to their reset values
    task t_rerst;
        i_scc_host.wr(15'h002b, 8'h04);
        @(posedge clock) #1 resetn = 1'b0;
        repeat (3) @(posedge clock) #1;
        resetn = 1'b1;
        chk({3'h0, gain, noise, proc_on, sdel}, 8'h11);
        rdchk(15'h002a, 8'h00, 1'b1);
        rdchk(15'h002b, 8'h11, 1'b1);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clock);
        #1 resetn = 1'b1;
        t_reset;
        t_fields;
        t_unmapped;
        t_sysref;
        t_proc_off;
        t_rerst;
        test_done;
    end
    // Watchdog against a hung run
    initial begin
        #100us;
        n_errors++;
        test_done;
    end
endmodule
